// file: design/irb_pkg.sv
// Purpose: shared constants and types for the cascade bus interface
// Assumes: 50 MHz system clock
// Notes:   counts derive from times written in their own units
`default_nettype none

package irb_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS   = 20;
    localparam int LED_HOLD_MS     = 30;
    // longest hold time, so round down
    localparam int LED_HOLD_CYC    = (LED_HOLD_MS * 1_000_000) / CLK_PERIOD_NS;
    localparam int BIT_TIME_NS     = 100;
    // half bus-clock period in system cycles, rounded down
    localparam int BUS_HALF_CYC    = BIT_TIME_NS / 2 / CLK_PERIOD_NS;

    // ----------------------------------------
    // sizes and reset values
    // ----------------------------------------
    localparam int  NUM_PORTS      = 9;
    localparam int  BYTE_W         = 8;
    localparam int  FIFO_DEPTH     = 8;
    localparam int  SYNC_W         = 5;
    localparam logic LED_OFF       = 1'b1;
    localparam logic LINE_IDLE     = 1'b1;

    // ----------------------------------------
    // serializer states, gray along the path
    // ----------------------------------------
    typedef enum logic [1:0] {
        IRB_SER_IDLE  = 2'b00,
        IRB_SER_SHIFT = 2'b01,
        IRB_SER_TAIL  = 2'b11
    } irb_ser_state_t;

endpackage : irb_pkg

`default_nettype wire

// file: design/irb_fifo.sv
// Purpose: small show-ahead fifo between the stream source and the serializer
// Assumes: one clock, synchronous active-low reset
// Notes:   depth must be a power of two
`default_nettype none

module irb_fifo #(
    parameter int WIDTH = irb_pkg::BYTE_W,
    parameter int DEPTH = irb_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;

    // ----------------------------------------
    // status, extra pointer bit tells full from empty
    // ----------------------------------------
    wire empty = (wr_q == rd_q);
    wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire push  = in_valid && !full;
    wire pop   = out_valid && out_ready;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_q[AW-1:0]];

    // storage has no reset, only pointers matter
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // pointer update
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end

endmodule : irb_fifo

`default_nettype wire

// file: design/irb_top.sv
// Purpose: cascade bus interface between repeater chips, plus global leds
// Assumes: user inputs are on clk; bus pins and ack input are asynchronous
// Notes:   the incoming bus clock is its own domain and may stop between frames
`default_nettype none

module irb_top #(
    parameter int NP       = irb_pkg::NUM_PORTS,
    parameter int HOLD_CYC = irb_pkg::LED_HOLD_CYC,
    parameter int HALF_CYC = irb_pkg::BUS_HALF_CYC
) (
    // system clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // link clock from another chip
    input  wire logic                      bus_serial_clock_i,
    // local port status
    input  wire logic [NP-1:0]             port_carrier,
    input  wire logic [NP-1:0]             port_collision,
    input  wire logic                      local_rx_active,
    input  wire logic                      rx_port_collision,
    input  wire logic                      tx_collision,
    input  wire logic                      local_arb_claim,
    input  wire logic                      backbone_partitioned,
    // outgoing stream
    input  wire logic                      tx_valid,
    output logic                           tx_ready,
    input  wire logic [irb_pkg::BYTE_W-1:0] tx_data,
    // incoming stream and bus status
    output logic                           rx_valid,
    output logic [irb_pkg::BYTE_W-1:0]     rx_data,
    output logic                           any_rx_activity,
    output logic                           other_port_active,
    output logic                           bus_port_collision,
    // arbitration chain
    input  wire logic                      arb_ack_in_n,
    output logic                           arb_ack_out_n,
    // shared bus lines
    input  wire logic                      bus_serial_data_i,
    output logic                           bus_serial_data_o,
    output logic                           bus_serial_data_oe,
    input  wire logic                      bus_frame_enable_n_i,
    output logic                           bus_frame_enable_n_o,
    output logic                           bus_frame_enable_n_oe,
    output logic                           bus_serial_clock_o,
    output logic                           bus_serial_clock_oe,
    input  wire logic                      rx_port_collision_n_i,
    output logic                           rx_port_collision_n_o,
    output logic                           rx_port_collision_n_oe,
    input  wire logic                      rx_activity_n_i,
    output logic                           rx_activity_n_o,
    output logic                           rx_activity_n_oe,
    input  wire logic                      other_port_activity_n_i,
    output logic                           other_port_activity_n_o,
    output logic                           other_port_activity_n_oe,
    // status leds
    output logic                           backbone_partition_led_n,
    output logic                           global_collision_led_n,
    output logic                           global_activity_led_n
);

    localparam int BW = irb_pkg::BYTE_W;
    localparam int CW = $clog2(HOLD_CYC + 1);
    localparam int HW = $clog2(HALF_CYC + 1);
    localparam logic LINE_IDLE_C = irb_pkg::LINE_IDLE;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // input synchronizers
    // ----------------------------------------
    logic [irb_pkg::SYNC_W-1:0] s1_q;
    logic [irb_pkg::SYNC_W-1:0] s2_q;
    logic                       lnk_tgl_q;
    logic                       tgl_seen_q;

    // only the second stage is read by logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // toggle bit resets low like its seen copy, so no false byte follows reset
            s1_q <= {{(irb_pkg::SYNC_W-1){irb_pkg::LINE_IDLE}}, 1'b0};
            s2_q <= {{(irb_pkg::SYNC_W-1){irb_pkg::LINE_IDLE}}, 1'b0};
        end else begin
            s1_q <= {arb_ack_in_n, rx_activity_n_i, other_port_activity_n_i,
                     rx_port_collision_n_i, lnk_tgl_q};
            s2_q <= s1_q;
        end
    end

    wire ack_in_n_s = s2_q[4];
    wire act_n_s    = s2_q[3];
    wire anyx_n_s   = s2_q[2];
    wire rx_port_collision_n_n_s   = s2_q[1];
    wire tgl_s      = s2_q[0];

    // ----------------------------------------
    // local event decode
    // ----------------------------------------
    wire any_car   = |port_carrier;
    wire any_col   = |port_collision;
    wire multi_col = |(port_collision & (port_collision - NP'(1)));
    logic car_prev_q;
    wire ev_start  = any_car && !car_prev_q;

    // ----------------------------------------
    // arbitration chain and wired-or lines
    // ----------------------------------------
    logic od_low_q;
    logic act_oe_q;
    logic anyx_oe_q;
    logic ack_out_q;
    logic act_s_q;
    logic anyx_s_q;
    logic rx_port_collision_n_s_q;

    // open-drain drive, low level only, enable decides
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            od_low_q  <= 1'b0;
            act_oe_q  <= 1'b0;
            anyx_oe_q <= 1'b0;
            ack_out_q <= LINE_IDLE_C;
        end else begin
            od_low_q  <= 1'b0;
            act_oe_q  <= local_rx_active || rx_port_collision;
            anyx_oe_q <= tx_collision || multi_col;
            // a claim here blocks every chip further down the chain
            ack_out_q <= ack_in_n_s && !local_arb_claim;
        end
    end

    // sensed bus state, active low lines turned into flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            act_s_q  <= 1'b0;
            anyx_s_q <= 1'b0;
            rx_port_collision_n_s_q <= 1'b0;
        end else begin
            act_s_q  <= !act_n_s;
            anyx_s_q <= !anyx_n_s;
            rx_port_collision_n_s_q <= !rx_port_collision_n_n_s;
        end
    end


    assign rx_activity_n_o          = od_low_q;
    assign rx_activity_n_oe         = act_oe_q;
    assign other_port_activity_n_o  = od_low_q;
    assign other_port_activity_n_oe = anyx_oe_q;
    assign arb_ack_out_n            = ack_out_q;
    assign any_rx_activity          = act_s_q;
    assign other_port_active        = anyx_s_q;
    assign bus_port_collision       = rx_port_collision_n_s_q;

    // ----------------------------------------
    // leds: activity and collision lit on event, held until timeout, collision also cut by the next carrier start; partition led follows its input
    // ----------------------------------------
    logic          part_q;
    logic [1:0]    led_q;
    logic [CW-1:0] hold_q [2];
    wire  [1:0]    led_ev = {any_car, any_col};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            part_q     <= irb_pkg::LED_OFF;
            car_prev_q <= 1'b0;
        end else begin
            part_q     <= !backbone_partitioned;
            car_prev_q <= any_car;
        end
    end

    // index 0 collision led, index 1 activity led
    for (genvar i = 0; i < 2; i++) begin : g_led
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                led_q[i]  <= irb_pkg::LED_OFF;
                hold_q[i] <= '0;
            end else if (led_ev[i]) begin
                led_q[i]  <= 1'b0;
                hold_q[i] <= CW'(HOLD_CYC);
            end else if (!led_q[i] && (hold_q[i] == '0 || ev_start)) begin
                led_q[i]  <= irb_pkg::LED_OFF;
            end else if (hold_q[i] != '0) begin
                hold_q[i] <= hold_q[i] - CW'(1);
            end
        end
    end

    assign backbone_partition_led_n = part_q;
    assign global_collision_led_n   = led_q[0];
    assign global_activity_led_n    = led_q[1];

    // ----------------------------------------
    // outgoing stream buffer
    // ----------------------------------------
    logic          ff_valid;
    logic [BW-1:0] ff_data;
    wire           ff_pop;

    irb_fifo #(
        .WIDTH (BW),
        .DEPTH (irb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (ff_valid),
        .out_ready (ff_pop),
        .out_data  (ff_data)
    );

    // ----------------------------------------
    // serializer, bus clock derived from clk
    // ----------------------------------------
    irb_pkg::irb_ser_state_t st_q;
    irb_pkg::irb_ser_state_t st_d;
    logic [HW-1:0] half_q;
    logic          sclk_q;
    logic          sdat_q;
    logic [BW-1:0] shreg_q;
    logic [3:0]    bits_q;
    logic          drive_q;
    logic          rx_port_collision_n_o_q;

    wire half_done = (half_q == HW'(HALF_CYC - 1));
    wire in_shift  = (st_q == irb_pkg::IRB_SER_SHIFT);
    wire fall      = half_done && sclk_q && in_shift;
    wire need_word = (bits_q == 4'h0);
    assign ff_pop  = fall && need_word && ff_valid;
    wire finish    = fall && need_word && !ff_valid && !local_rx_active;

    // next state; underrun holds the last bit rather than ending early
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            irb_pkg::IRB_SER_IDLE:  if (local_rx_active) st_d = irb_pkg::IRB_SER_SHIFT;
            irb_pkg::IRB_SER_SHIFT: if (finish) st_d = irb_pkg::IRB_SER_TAIL;
            irb_pkg::IRB_SER_TAIL:  if (half_done) st_d = irb_pkg::IRB_SER_IDLE;
            default:                st_d = irb_pkg::IRB_SER_IDLE;
        endcase
    end

    // state, line ownership and bus clock divider
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q    <= irb_pkg::IRB_SER_IDLE;
            drive_q <= 1'b0;
            half_q  <= '0;
            sclk_q  <= LINE_IDLE_C;
        end else begin
            st_q    <= st_d;
            drive_q <= (st_d != irb_pkg::IRB_SER_IDLE);
            half_q  <= (half_done || st_q == irb_pkg::IRB_SER_IDLE) ? '0 : half_q + HW'(1);
            sclk_q  <= (st_q == irb_pkg::IRB_SER_IDLE) ? LINE_IDLE_C : sclk_q ^ half_done;
        end
    end

    // data moves only as our clock falls, lsb first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdat_q  <= LINE_IDLE_C;
            shreg_q <= '0;
            bits_q  <= 4'h0;
        end else if (ff_pop) begin
            sdat_q  <= ff_data[0];
            shreg_q <= ff_data >> 1;
            bits_q  <= 4'(BW - 1);
        end else if (fall && !need_word) begin
            sdat_q  <= shreg_q[0];
            shreg_q <= shreg_q >> 1;
            bits_q  <= bits_q - 4'h1;
        end
    end

    // collision on the receiving port, sent only while we own the bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_port_collision_n_o_q <= LINE_IDLE_C;
        end else begin
            rx_port_collision_n_o_q <= !rx_port_collision;
        end
    end

    assign bus_serial_data_o      = sdat_q;
    assign bus_serial_data_oe     = drive_q;
    assign bus_frame_enable_n_o   = od_low_q;
    assign bus_frame_enable_n_oe  = drive_q;
    assign bus_serial_clock_o     = sclk_q;
    assign bus_serial_clock_oe    = drive_q;
    assign rx_port_collision_n_o  = rx_port_collision_n_o_q;
    assign rx_port_collision_n_oe = drive_q;

    // ----------------------------------------
    // deserializer on the incoming bus clock
    // ----------------------------------------
    logic          lrst1_q;
    logic          lrst2_q;
    logic [BW-1:0] lsh_q;
    logic [BW-1:0] lhold_q;
    logic [3:0]    lcnt_q;

    // reset reaches the link side as a level; needs a few link edges
    always_ff @(posedge bus_serial_clock_i) begin
        lrst1_q <= rst_n;
        lrst2_q <= lrst1_q;
    end

    // a finished byte is parked and announced by a toggle
    always_ff @(posedge bus_serial_clock_i) begin
        if (!lrst2_q || bus_frame_enable_n_i) begin
            lcnt_q <= 4'h0;
            lsh_q  <= '0;
        end else begin
            lsh_q  <= {bus_serial_data_i, lsh_q[BW-1:1]};
            lcnt_q <= (lcnt_q == 4'(BW - 1)) ? 4'h0 : lcnt_q + 4'h1;
        end
    end

    always_ff @(posedge bus_serial_clock_i) begin
        if (!lrst2_q) begin
            lnk_tgl_q <= 1'b0;
            lhold_q   <= '0;
        end else if (!bus_frame_enable_n_i && lcnt_q == 4'(BW - 1)) begin
            lnk_tgl_q <= !lnk_tgl_q;
            lhold_q   <= {bus_serial_data_i, lsh_q[BW-1:1]};
        end
    end

    // parked byte is stable for a whole byte time after the toggle
    logic          rxv_q;
    logic [BW-1:0] rxd_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tgl_seen_q <= 1'b0;
            rxv_q      <= 1'b0;
            rxd_q      <= '0;
        end else begin
            tgl_seen_q <= tgl_s;
            rxv_q      <= (tgl_s != tgl_seen_q) && !drive_q;
            rxd_q      <= (tgl_s != tgl_seen_q) ? lhold_q : rxd_q;
        end
    end

    assign rx_valid = rxv_q;
    assign rx_data  = rxd_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_partition_led: assert property (1'b1 |=> backbone_partition_led_n == !$past(backbone_partitioned))
        else $error("partition led does not follow partition state");
    a_global_collision_led_n_lit: assert property (any_col |=> !global_collision_led_n)
        else $error("collision led not lit after collision");
    a_global_activity_led_n_hold: assert property (any_car ##1 !any_car [*2] |-> !global_activity_led_n)
        else $error("activity led released too soon");
    a_ack_pass: assert property (local_arb_claim |=> !arb_ack_out_n)
        else $error("claim not passed down the chain");
    a_data_edge: assert property ($changed(bus_serial_data_o) |-> $fell(bus_serial_clock_o))
        else $error("serial data moved off the falling clock");
    a_frame_start: assert property (local_rx_active && st_q == irb_pkg::IRB_SER_IDLE |=> bus_frame_enable_n_oe && !bus_frame_enable_n_o)
        else $error("frame enable not asserted on receive");
    a_lines_free: assert property (!local_rx_active && st_q == irb_pkg::IRB_SER_IDLE |=> !bus_serial_clock_oe && !bus_serial_data_oe)
        else $error("bus lines driven while not receiving");
    a_rx_port_collision_n_drive: assert property (rx_port_collision |=> !rx_port_collision_n_o)
        else $error("port collision line not asserted");
    a_act_pull: assert property ((local_rx_active || rx_port_collision) |=> rx_activity_n_oe && !rx_activity_n_o)
        else $error("receive activity not pulled low");
    a_anyx_pull: assert property ((tx_collision || multi_col) |=> other_port_activity_n_oe)
        else $error("other activity not pulled low");
    a_act_sense: assert property (##3 any_rx_activity == !$past(rx_activity_n_i, 3))
        else $error("receive activity sense wrong");

endmodule : irb_top

`default_nettype wire

// file: verif/irb_peer.sv
// Purpose: model of another cascaded chip that frames and clocks a stream
// Assumes: released lines idle high through pull-ups
// Notes:   link clock stands high outside frames
`default_nettype none

module irb_peer (
    // link lines this chip drives
    output logic link_clk,
    output logic link_data,
    output logic link_oe,
    output logic frame_n,
    // open-drain pulls, high means pulling low
    output logic act_pull,
    output logic other_pull
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {link_clk, link_data, link_oe, frame_n, act_pull, other_pull} = 6'b110100;
    end

    // ----------------------------------------
    // frame: three lead-in clocks with enable high, then n bits lsb first
    // ----------------------------------------
    task automatic send_frame(input logic [23:0] bits, input int n);
        link_oe  = 1'b1;
        act_pull = 1'b1;
        for (int i = -3; i < n; i++) begin
            #7.5;
            link_clk = 1'b0;
            frame_n  = (i < 0);
            if (i >= 0) link_data = bits[i];
            #7.5;
            link_clk = 1'b1;
        end
        #7.5;
        frame_n   = 1'b1;
        link_oe   = 1'b0;
        act_pull  = 1'b0;
        link_data = ~link_data; // released value is not the last bit
    endtask : send_frame

    // transmit or multi-port collision seen by this chip
    task automatic pull_other(input logic v);
        other_pull = v;
    endtask : pull_other
endmodule : irb_peer

`default_nettype wire

// file: verif/irb_top_tb.sv
// Purpose: self-checking bench for the cascade bus interface
// Assumes: one peer chip on the shared lines
// Notes:   led hold shortened to 20 cycles
`default_nettype none

module irb_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HOLD = 20;
    logic clk = 0, rst_n = 0;
    logic [8:0] port_carrier, port_collision;
    logic [7:0] tx_data, rx_data;
    logic local_rx_active, rx_port_collision, tx_collision, local_arb_claim, backbone_partitioned;
    logic tx_valid, tx_ready, rx_valid, any_rx_activity, other_port_active, bus_port_collision;
    logic arb_ack_in_n, arb_ack_out_n, bus_serial_data_o, bus_serial_data_oe, bus_frame_enable_n_o;
    logic bus_frame_enable_n_oe, bus_serial_clock_o, bus_serial_clock_oe, rx_port_collision_n_o;
    logic rx_port_collision_n_oe, rx_activity_n_o, rx_activity_n_oe, other_port_activity_n_o;
    logic other_port_activity_n_oe, backbone_partition_led_n, global_collision_led_n, global_activity_led_n;
    logic p_clk, p_data, p_oe, p_frame_n, p_act, p_other;
    int n_errors = 0, n_compared = 0, n_bad = 0, nbits = 0;
    logic [63:0] cap;
    logic [7:0] rxq[$];
    logic pd, pc;

    // ----------------------------------------
    // wire levels from every party, pull-ups when released
    // ----------------------------------------
    wire logic bus_serial_clock_i = bus_serial_clock_oe ? bus_serial_clock_o : (p_oe ? p_clk : 1'b1);
    wire logic bus_serial_data_i = bus_serial_data_oe ? bus_serial_data_o : (p_oe ? p_data : 1'b1);
    wire logic bus_frame_enable_n_i = bus_frame_enable_n_oe ? bus_frame_enable_n_o : (p_oe ? p_frame_n : 1'b1);
    wire logic rx_port_collision_n_i = rx_port_collision_n_oe ? rx_port_collision_n_o : 1'b1;
    wire logic rx_activity_n_i = (rx_activity_n_oe ? rx_activity_n_o : 1'b1) && !p_act;
    wire logic other_port_activity_n_i = (other_port_activity_n_oe ? other_port_activity_n_o : 1'b1) && !p_other;

    irb_top #(.HOLD_CYC(HOLD)) dut (.clk, .rst_n, .bus_serial_clock_i, .port_carrier, .port_collision,
        .local_rx_active, .rx_port_collision, .tx_collision, .local_arb_claim, .backbone_partitioned,
        .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data, .any_rx_activity, .other_port_active,
        .bus_port_collision, .arb_ack_in_n, .arb_ack_out_n, .bus_serial_data_i, .bus_serial_data_o,
        .bus_serial_data_oe, .bus_frame_enable_n_i, .bus_frame_enable_n_o, .bus_frame_enable_n_oe,
        .bus_serial_clock_o, .bus_serial_clock_oe, .rx_port_collision_n_i, .rx_port_collision_n_o,
        .rx_port_collision_n_oe, .rx_activity_n_i, .rx_activity_n_o, .rx_activity_n_oe,
        .other_port_activity_n_i, .other_port_activity_n_o, .other_port_activity_n_oe,
        .backbone_partition_led_n, .global_collision_led_n, .global_activity_led_n);
    irb_peer peer (.link_clk(p_clk), .link_data(p_data), .link_oe(p_oe), .frame_n(p_frame_n),
        .act_pull(p_act), .other_pull(p_other));

    always #10 clk = ~clk;

    // ----------------------------------------
    // monitors: serial capture, edge discipline, received bytes
    // ----------------------------------------
    always @(posedge bus_serial_clock_o) if (bus_serial_clock_oe && nbits < 64) begin
        cap = {bus_serial_data_o, cap[63:1]};
        nbits++;
    end
    // data may move only where the driven clock falls; enable stays low
    always @(posedge clk) #1 begin
        if (bus_serial_data_oe === 1'b1 && ((bus_serial_data_o !== pd && !(pc && !bus_serial_clock_o))
            || bus_frame_enable_n_o !== 1'b0)) n_bad++;
        pd = bus_serial_data_o;
        pc = bus_serial_clock_o;
    end
    always @(posedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic t_leds;
        backbone_partitioned = 1; step(2);
        chk("partition led", 0, backbone_partition_led_n);
        backbone_partitioned = 0; step(2);
        chk("partition led", 1, backbone_partition_led_n);
        port_carrier[4] = 1; port_collision[4] = 1; step(3);
        chk("activity led", 0, global_activity_led_n);
        chk("collision led", 0, global_collision_led_n);
        port_carrier[4] = 0; port_collision[4] = 0; step(HOLD - 4);
        chk("activity held", 0, global_activity_led_n);
        chk("collision held", 0, global_collision_led_n);
        step(10);
        chk("activity off", 1, global_activity_led_n);
        chk("collision off", 1, global_collision_led_n);
        port_carrier[1] = 1; port_collision[1] = 1; step(3);
        port_carrier[1] = 0; port_collision[1] = 0; step(4);
        port_carrier[7] = 1; step(3);
        chk("collision cut by event", 1, global_collision_led_n);
        chk("activity new event", 0, global_activity_led_n);
        port_carrier[7] = 0; step(HOLD + 10);
        $display("test leds done");
    endtask : t_leds

    task automatic t_arb;
        chk("ack idle", 1, arb_ack_out_n);
        local_arb_claim = 1; step(2);
        chk("ack claim", 0, arb_ack_out_n);
        local_arb_claim = 0; arb_ack_in_n = 0; step(5);
        chk("ack passed", 0, arb_ack_out_n);
        arb_ack_in_n = 1; step(5);
        chk("ack top", 1, arb_ack_out_n);
        $display("test arbitration done");
    endtask : t_arb

    task automatic t_od;
        rx_port_collision = 1; step(5);
        chk("rx act pull", 1, rx_activity_n_oe);
        chk("rx act sense", 1, any_rx_activity);
        chk("col line free", 0, rx_port_collision_n_oe);
        rx_port_collision = 0; port_collision = 9'h004; step(5);
        chk("one port col", 0, other_port_activity_n_oe);
        port_collision = 9'h003; step(5);
        chk("multi col pull", 1, other_port_activity_n_oe);
        chk("multi col sense", 1, other_port_active);
        chk("rx act off", 0, rx_activity_n_oe);
        port_collision = 0; tx_collision = 1; step(5);
        chk("tx col pull", 1, other_port_activity_n_oe);
        tx_collision = 0; peer.pull_other(1); step(5);
        chk("peer other", 1, other_port_active);
        peer.pull_other(0); step(5);
        chk("other idle", 0, other_port_active);
        chk("rx act idle", 0, any_rx_activity);
        step(HOLD + 10);
        $display("test open drain done");
    endtask : t_od

    task automatic t_tx;
        logic [63:0] exp;
        for (int k = 0; k < 9; k++) begin
            tx_valid = 1;
            tx_data = 8'(8'h5A + 8'h27 * k);
            if (k < 8) exp[8*k+:8] = tx_data;
            step(1);
        end
        chk("fifo full", 0, tx_ready);
        tx_valid = 0; nbits = 0; n_bad = 0;
        local_rx_active = 1; rx_port_collision = 1; step(3);
        chk("drive oe", 4'hF, {bus_serial_data_oe, bus_frame_enable_n_oe, bus_serial_clock_oe,
            rx_port_collision_n_oe});
        chk("frame low", 0, bus_frame_enable_n_o);
        chk("port col", 0, rx_port_collision_n_o);
        step(2);
        chk("port col sense", 1, bus_port_collision);
        rx_port_collision = 0;
        for (int i = 0; i < 600 && nbits < 64; i++) step(1);
        local_rx_active = 0; step(12);
        chk("released", 0, bus_serial_data_oe | bus_serial_clock_oe);
        chk("serial bits", exp, cap);
        chk("edge faults", 0, n_bad);
        $display("test transmit done");
    endtask : t_tx

    task automatic t_rx;
        rxq.delete();
        fork
            peer.send_frame(24'h0E_C396, 20);
            begin
                #200;
                chk("peer act", 1, any_rx_activity);
                chk("not driving", 0, bus_serial_data_oe);
            end
        join
        step(10);
        chk("rx count", 2, rxq.size());
        chk("rx data", 16'hC396, {rxq[1], rxq[0]});
        $display("test receive done");
    endtask : t_rx

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    initial begin
        {port_carrier, port_collision, tx_data} = '0;
        {local_rx_active, rx_port_collision, tx_collision, local_arb_claim} = '0;
        {backbone_partitioned, tx_valid} = '0;
        arb_ack_in_n = 1;
        // start after the peer's own idle levels are set, so its reset clocks reach the link
        fork begin #1 peer.send_frame(24'h0, 0); end join_none
        step(8);
        rst_n = 1;
        step(4);
        t_leds; t_arb; t_od; t_tx; t_rx;
        stop_test;
    end

    // watchdog well past the few hundred cycles the tests need
    initial begin
        repeat (8000) @(posedge clk);
        n_errors++;
        $display("watchdog expired");
        stop_test;
    end
endmodule : irb_top_tb

`default_nettype wire
